// ===== hw/tmde_unit.sv
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module tmde_unit (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [tmde_pkg::ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [tmde_pkg::ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  input wire logic d_req,
  input wire logic [31:0] d_addr,
  input wire logic [31:0] d_pc,
  input wire tmde_pkg::tmde_op_t d_op,
  input wire logic d_entry_hit,
  input wire logic i_exec,
  input wire logic [31:0] i_pc,
  input wire logic i_fetch_miss,
  input wire logic [tmde_pkg::DBG_SYNC_W-1:0] dbg_sync_evt,
  input wire logic dbg_except_evt,
  input wire logic dbg_uncond_evt,
  input wire logic [31:0] dbg_cause_pc,
  input wire logic [31:0] dbg_orig_vector,
  input wire logic [31:0] dbg_next_pc,
  input wire logic crit_ret_exec,
  output logic kill_commit,
  output logic redirect_valid,
  output logic [31:0] redirect_pc,
  output logic [31:0] msr_out
);
  import tmde_pkg::*;

  localparam logic [31:0] SYN_KEEP = 32'h1 << SYN_MCHK_BIT;
  localparam logic [31:0] SYN_STORE = 32'h1 << SYN_STORE_BIT;

  logic wr_en;
  logic wr_ok;
  logic rd_ok;
  logic [ADDR_W-1:0] wr_addr;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] wr_data;
  logic [31:0] rd_data;
  logic [3:0] wr_strb;

  logic [15:0] vector_prefix_reg;
  logic [31:0] machine_state_reg;
  logic [31:0] save_pc_reg;
  logic [31:0] save_msr_reg;
  logic [31:0] crit_save_pc_reg;
  logic [31:0] crit_save_msr_reg;
  logic [31:0] fault_data_addr_reg;
  logic [31:0] exception_syndrome_reg;
  logic [DBG_W-1:0] debug_event_status_reg;

  logic dbg_any;
  logic [31:0] dbg_pc;
  logic [DBG_W-1:0] dbg_status;
  logic dmiss;
  logic imiss;
  logic dbg_take;
  logic take_dmiss;
  logic take_imiss;
  logic take_ret;
  logic is_store;
  logic [31:0] next_pc;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] val,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    merge = res;
  endfunction : merge

  function automatic logic hit(input logic [ADDR_W-1:0] off);
    hit = wr_en && (wr_addr == off);
  endfunction : hit

  tmde_axil u_axil (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  tmde_dbgsel u_dbgsel (
    .sync_evt(dbg_sync_evt),
    .except_evt(dbg_except_evt),
    .uncond_evt(dbg_uncond_evt),
    .cause_pc(dbg_cause_pc),
    .orig_vector(dbg_orig_vector),
    .next_pc(dbg_next_pc),
    .any(dbg_any),
    .save_pc(dbg_pc),
    .status(dbg_status)
  );

  // the translation unit reports a hit only for a valid entry whose
  // address and process identifier both match
  assign dmiss = d_req && machine_state_reg[MSR_DXL_BIT] &&
                 !d_entry_hit;
  assign imiss = i_exec && machine_state_reg[MSR_IXL_BIT] &&
                 i_fetch_miss;
  assign dbg_take = dbg_any && machine_state_reg[MSR_DBG_EN_BIT];
  // one redirect per cycle: debug, then data miss, then fetch miss
  assign take_dmiss = dmiss && !dbg_take;
  assign take_imiss = imiss && !dbg_take && !dmiss;
  assign take_ret = crit_ret_exec && !dbg_take && !dmiss && !imiss;
  // combinational so the pipeline can drop the commit in this cycle
  assign kill_commit = take_dmiss || take_imiss;
  assign is_store = (d_op != TMDE_OP_LOAD);
  assign msr_out = machine_state_reg;

  always_comb begin
    next_pc = crit_save_pc_reg;
    if (dbg_take) begin
      next_pc = tmde_vec(vector_prefix_reg, VEC_DEBUG);
    end else if (take_dmiss) begin
      next_pc = tmde_vec(vector_prefix_reg, VEC_DMISS);
    end else if (take_imiss) begin
      next_pc = tmde_vec(vector_prefix_reg, VEC_IMISS);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      redirect_valid <= 1'b0;
      redirect_pc <= RST_WORD;
    end else begin
      redirect_valid <= dbg_take || take_dmiss || take_imiss || take_ret;
      if (dbg_take || take_dmiss || take_imiss || take_ret) begin
        redirect_pc <= next_pc;
      end
    end
  end

  // hardware capture wins over a software write in the same cycle
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      save_pc_reg <= RST_WORD;
    end else if (take_dmiss) begin
      save_pc_reg <= d_pc;
    end else if (take_imiss) begin
      save_pc_reg <= i_pc;
    end else if (hit(OFF_SAVE_PC)) begin
      save_pc_reg <= merge(save_pc_reg, wr_data, wr_strb);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      save_msr_reg <= RST_WORD;
    end else if (take_dmiss || take_imiss) begin
      save_msr_reg <= machine_state_reg;
    end else if (hit(OFF_SAVE_MSR)) begin
      save_msr_reg <= merge(save_msr_reg, wr_data, wr_strb);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      fault_data_addr_reg <= RST_WORD;
    end else if (take_dmiss) begin
      fault_data_addr_reg <= d_addr;
    end else if (hit(OFF_FAULT_DATA_ADDR)) begin
      fault_data_addr_reg <= merge(fault_data_addr_reg, wr_data, wr_strb);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      exception_syndrome_reg <= RST_WORD;
    end else if (take_dmiss) begin
      exception_syndrome_reg <= (exception_syndrome_reg & SYN_KEEP) |
                                (is_store ? SYN_STORE : RST_WORD);
    end else if (hit(OFF_SYNDROME)) begin
      exception_syndrome_reg <= merge(exception_syndrome_reg, wr_data,
                                      wr_strb);
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      crit_save_pc_reg <= RST_WORD;
      crit_save_msr_reg <= RST_WORD;
    end else if (dbg_take) begin
      crit_save_pc_reg <= dbg_pc;
      crit_save_msr_reg <= machine_state_reg;
    end else begin
      if (hit(OFF_CRIT_SAVE_PC)) begin
        crit_save_pc_reg <= merge(crit_save_pc_reg, wr_data, wr_strb);
      end
      if (hit(OFF_CRIT_SAVE_MSR)) begin
        crit_save_msr_reg <= merge(crit_save_msr_reg, wr_data, wr_strb);
      end
    end
  end

  // write one to clear; a new event in the same cycle stays set
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      debug_event_status_reg <= '0;
    end else begin
      debug_event_status_reg <= (debug_event_status_reg &
        ~((hit(OFF_DEBUG_STATUS) && wr_strb[0]) ? wr_data[DBG_W-1:0] :
        {DBG_W{1'b0}})) |
        (dbg_take ? dbg_status : {DBG_W{1'b0}});
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      machine_state_reg <= RST_WORD;
    end else if (take_ret) begin
      machine_state_reg <= crit_save_msr_reg;
    end else if (hit(OFF_MACHINE_STATE)) begin
      machine_state_reg <= merge(machine_state_reg, wr_data, wr_strb);
    end
  end

  // only the upper half of the prefix word is stored
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      vector_prefix_reg <= RST_PREFIX;
    end else if (hit(OFF_VECTOR_PREFIX)) begin
      vector_prefix_reg <= 16'(merge({vector_prefix_reg, 16'h0000}, wr_data,
                                     wr_strb) >> 16);
    end
  end

  always_comb begin
    rd_ok = 1'b1;
    case (rd_addr)
      OFF_VECTOR_PREFIX: rd_data = {vector_prefix_reg, 16'h0000};
      OFF_MACHINE_STATE: rd_data = machine_state_reg;
      OFF_SAVE_PC: rd_data = save_pc_reg;
      OFF_SAVE_MSR: rd_data = save_msr_reg;
      OFF_CRIT_SAVE_PC: rd_data = crit_save_pc_reg;
      OFF_CRIT_SAVE_MSR: rd_data = crit_save_msr_reg;
      OFF_FAULT_DATA_ADDR: rd_data = fault_data_addr_reg;
      OFF_SYNDROME: rd_data = exception_syndrome_reg;
      OFF_DEBUG_STATUS: rd_data = {24'h000000, debug_event_status_reg};
      default: begin
        rd_data = RST_WORD;
        rd_ok = 1'b0;
      end
    endcase
  end

  assign wr_ok = (wr_addr <= OFF_DEBUG_STATUS);

  dmiss_detect_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (d_req && machine_state_reg[MSR_DXL_BIT] && !d_entry_hit && !dbg_take)
    |-> kill_commit ##1 redirect_valid)
    else $error("data miss not taken");
  dmiss_pc_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    take_dmiss |=> save_pc_reg == $past(d_pc))
    else $error("data miss pc not saved");
  dmiss_addr_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    take_dmiss |=> fault_data_addr_reg == $past(d_addr))
    else $error("fault address not captured");
  dmiss_esr_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    take_dmiss |=> exception_syndrome_reg ==
      (($past(exception_syndrome_reg) & SYN_KEEP) |
       (($past(d_op) != TMDE_OP_LOAD) ? SYN_STORE : 32'h0)))
    else $error("syndrome wrong after data miss");
  dmiss_vec_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    take_dmiss |=> redirect_valid &&
      redirect_pc == {$past(vector_prefix_reg), 16'h1100})
    else $error("data miss vector wrong");
  miss_msr_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (take_dmiss || take_imiss) |=>
      save_msr_reg == $past(machine_state_reg))
    else $error("state not saved on miss");
  imiss_pc_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (i_exec && i_fetch_miss && machine_state_reg[MSR_IXL_BIT] &&
     !dbg_take && !dmiss) |=> save_pc_reg == $past(i_pc))
    else $error("fetch miss pc not saved");
  imiss_vec_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    take_imiss |=> redirect_valid &&
      redirect_pc == {$past(vector_prefix_reg), 16'h1200})
    else $error("fetch miss vector wrong");
  dbg_entry_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    dbg_take |=> crit_save_msr_reg == $past(machine_state_reg) &&
      redirect_pc == {$past(vector_prefix_reg), 16'h2000})
    else $error("debug entry wrong");
  dbg_follow_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    (dbg_take && dbg_sync_evt[DBG_ICOMP] && !dbg_sync_evt[DBG_BRANCH] &&
     !dbg_sync_evt[DBG_DAC] && !dbg_sync_evt[DBG_IADDR] &&
     !dbg_sync_evt[DBG_TRAP]) |=>
      crit_save_pc_reg == $past(dbg_cause_pc) + 32'h4)
    else $error("following address wrong");
  crit_ret_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    take_ret |=> machine_state_reg == $past(crit_save_msr_reg) &&
      redirect_pc == $past(crit_save_pc_reg))
    else $error("critical return wrong");
  dbg_status_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    dbg_take |=> (debug_event_status_reg & $past(dbg_status)) ==
      $past(dbg_status))
    else $error("debug status bit lost");
  kill_redir_a: assert property (@(posedge clk_sys) disable iff (!nrst)
    kill_commit |=> redirect_valid ##1 !redirect_valid)
    else $error("kill without single redirect");
endmodule : tmde_unit
`default_nettype wire

// ===== hw/tmde_pkg.sv
`default_nettype none
package tmde_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register offsets (byte addresses, one word each)
  localparam logic [7:0] OFF_VECTOR_PREFIX = 8'h00;
  localparam logic [7:0] OFF_MACHINE_STATE = 8'h04;
  localparam logic [7:0] OFF_SAVE_PC = 8'h08;
  localparam logic [7:0] OFF_SAVE_MSR = 8'h0c;
  localparam logic [7:0] OFF_CRIT_SAVE_PC = 8'h10;
  localparam logic [7:0] OFF_CRIT_SAVE_MSR = 8'h14;
  localparam logic [7:0] OFF_FAULT_DATA_ADDR = 8'h18;
  localparam logic [7:0] OFF_SYNDROME = 8'h1c;
  localparam logic [7:0] OFF_DEBUG_STATUS = 8'h20;

  // machine state bits that steer this block
  localparam int MSR_DXL_BIT = 4;
  localparam int MSR_IXL_BIT = 5;
  localparam int MSR_DBG_EN_BIT = 9;

  // syndrome fields
  localparam int SYN_STORE_BIT = 23;
  localparam int SYN_MCHK_BIT = 31;

  // debug event bit positions in the status register
  localparam int DBG_BRANCH = 0;
  localparam int DBG_DAC = 1;
  localparam int DBG_DVAL = 2;
  localparam int DBG_IADDR = 3;
  localparam int DBG_ICOMP = 4;
  localparam int DBG_TRAP = 5;
  localparam int DBG_EXCEPT = 6;
  localparam int DBG_UNCOND = 7;
  localparam int DBG_W = 8;
  localparam int DBG_SYNC_W = 6;

  // vector offsets and instruction step
  localparam logic [15:0] VEC_DMISS = 16'h1100;
  localparam logic [15:0] VEC_IMISS = 16'h1200;
  localparam logic [15:0] VEC_DEBUG = 16'h2000;
  localparam logic [31:0] INSTR_STEP = 32'h0000_0004;

  // reset values
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [15:0] RST_PREFIX = 16'h0000;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    TMDE_OP_LOAD = 3'b000,
    TMDE_OP_STORE = 3'b001,
    TMDE_OP_CBLK_ZERO = 3'b010,
    TMDE_OP_CBLK_INVAL = 3'b011,
    TMDE_OP_CCONG_INVAL = 3'b100
  } tmde_op_t;

  function automatic logic [31:0] tmde_vec(input logic [15:0] prefix,
                                           input logic [15:0] off);
    tmde_vec = {prefix, off};
  endfunction : tmde_vec
endpackage : tmde_pkg
`default_nettype wire

// ===== hw/tmde_axil.sv
`timescale 1ns/1ps
`default_nettype none
module tmde_axil (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic [tmde_pkg::ADDR_W-1:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  input wire logic [tmde_pkg::ADDR_W-1:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  output logic wr_en,
  output logic [tmde_pkg::ADDR_W-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic [tmde_pkg::ADDR_W-1:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);
  import tmde_pkg::*;

  logic aw_full;
  logic w_full;
  logic [ADDR_W-1:0] aw_q;

  assign s_awready = !aw_full;
  assign s_wready = !w_full;
  assign s_arready = !s_rvalid;
  // the write fires only once both halves are held and no answer waits
  assign wr_en = aw_full && w_full && !s_bvalid;
  assign wr_addr = {aw_q[ADDR_W-1:2], 2'b00};
  assign rd_addr = {s_araddr[ADDR_W-1:2], 2'b00};

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      aw_full <= 1'b0;
      aw_q <= '0;
    end else if (s_awvalid && s_awready) begin
      aw_full <= 1'b1;
      aw_q <= s_awaddr;
    end else if (wr_en) begin
      aw_full <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      w_full <= 1'b0;
      wr_data <= RST_WORD;
      wr_strb <= 4'h0;
    end else if (s_wvalid && s_wready) begin
      w_full <= 1'b1;
      wr_data <= s_wdata;
      wr_strb <= s_wstrb;
    end else if (wr_en) begin
      w_full <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OKAY;
    end else if (wr_en) begin
      s_bvalid <= 1'b1;
      s_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_bready) begin
      s_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s_rvalid <= 1'b0;
      s_rdata <= RST_WORD;
      s_rresp <= RESP_OKAY;
    end else if (s_arvalid && s_arready) begin
      s_rvalid <= 1'b1;
      s_rdata <= rd_data;
      s_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_rready) begin
      s_rvalid <= 1'b0;
    end
  end
endmodule : tmde_axil
`default_nettype wire

// ===== hw/tmde_dbgsel.sv
`timescale 1ns/1ps
`default_nettype none
module tmde_dbgsel (
  input wire logic [tmde_pkg::DBG_SYNC_W-1:0] sync_evt,
  input wire logic except_evt,
  input wire logic uncond_evt,
  input wire logic [31:0] cause_pc,
  input wire logic [31:0] orig_vector,
  input wire logic [31:0] next_pc,
  output logic any,
  output logic [31:0] save_pc,
  output logic [tmde_pkg::DBG_W-1:0] status
);
  import tmde_pkg::*;

  logic at_cause;
  logic after_cause;

  // sync events sit in the low bits, the two async ones above them
  assign status = {uncond_evt, except_evt, sync_evt};
  assign any = |status;
  assign at_cause = sync_evt[DBG_BRANCH] | sync_evt[DBG_DAC] |
                    sync_evt[DBG_IADDR] | sync_evt[DBG_TRAP];
  assign after_cause = sync_evt[DBG_DVAL] | sync_evt[DBG_ICOMP];

  // events tied to the current instruction win over async ones
  always_comb begin
    if (at_cause) begin
      save_pc = cause_pc;
    end else if (after_cause) begin
      save_pc = cause_pc + INSTR_STEP;
    end else if (except_evt) begin
      save_pc = orig_vector;
    end else begin
      save_pc = next_pc;
    end
  end
endmodule : tmde_dbgsel
`default_nettype wire

// ===== test/tmde_xlate_model.sv
`timescale 1ns/1ps
`default_nettype none
module tmde_xlate_model #(
  parameter logic [19:0] MAPPED_PAGE = 20'h00010
) (
  input wire logic d_req,
  input wire logic [31:0] d_addr,
  input wire logic i_exec,
  input wire logic [31:0] i_pc,
  output logic d_entry_hit,
  output logic i_fetch_miss
);
  // one mapped page only, so a miss is cheap to provoke from the bench
  assign d_entry_hit = d_req && (d_addr[31:12] == MAPPED_PAGE);
  assign i_fetch_miss = i_exec && (i_pc[31:12] != MAPPED_PAGE);
endmodule : tmde_xlate_model
`default_nettype wire

// ===== test/tmde_unit_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
  n_checks++; \
  if ((g) !== (e)) begin \
    n_errors++; \
    $display("mismatch %s exp %h got %h", nm, e, g); \
  end \
end
module tmde_unit_tb_top;
  import tmde_pkg::*;
  localparam logic [31:0] MSR_ON = 32'h0000_0230;
  int n_errors = 0, n_checks = 0, cyc = 0;
  logic clk_sys = 1'b0, nrst = 1'b0;
  logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
  logic s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic s_arvalid = 1'b0, s_rready = 1'b0;
  logic [31:0] s_wdata = 32'h0, s_rdata;
  logic [3:0] s_wstrb = 4'hf;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  logic [1:0] s_bresp, s_rresp;
  logic d_req = 1'b0, i_exec = 1'b0, crit_ret_exec = 1'b0;
  logic [31:0] d_addr = 32'h0, d_pc = 32'h0, i_pc = 32'h0;
  tmde_op_t d_op = TMDE_OP_LOAD;
  logic d_entry_hit, i_fetch_miss, kill_commit, redirect_valid;
  logic [5:0] dbg_sync_evt = 6'h00;
  logic dbg_except_evt = 1'b0, dbg_uncond_evt = 1'b0;
  logic [31:0] dbg_cause_pc = 32'h0001_0800, dbg_orig_vector = 32'habcd0700;
  logic [31:0] dbg_next_pc = 32'h0001_0a00, redirect_pc, msr_out;

  tmde_unit u_tmde_unit (
    .clk_sys(clk_sys), .nrst(nrst),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
    .s_rvalid(s_rvalid), .s_rready(s_rready), .d_req(d_req), .d_addr(d_addr),
    .d_pc(d_pc), .d_op(d_op), .d_entry_hit(d_entry_hit), .i_exec(i_exec),
    .i_pc(i_pc), .i_fetch_miss(i_fetch_miss), .dbg_sync_evt(dbg_sync_evt),
    .dbg_except_evt(dbg_except_evt), .dbg_uncond_evt(dbg_uncond_evt),
    .dbg_cause_pc(dbg_cause_pc), .dbg_orig_vector(dbg_orig_vector),
    .dbg_next_pc(dbg_next_pc), .crit_ret_exec(crit_ret_exec),
    .kill_commit(kill_commit), .redirect_valid(redirect_valid),
    .redirect_pc(redirect_pc), .msr_out(msr_out));

  tmde_xlate_model u_xlate (
    .d_req(d_req), .d_addr(d_addr), .i_exec(i_exec), .i_pc(i_pc),
    .d_entry_hit(d_entry_hit), .i_fetch_miss(i_fetch_miss));

  always #20 clk_sys = ~clk_sys;

  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  // hang guard: the whole run needs well under a thousand cycles
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      print_verdict();
    end
  end

  // readies are looked at on the falling edge, where they have settled
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    logic aw_done, w_done, aw_hit, w_hit;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge clk_sys);
    s_awaddr <= a;
    s_awvalid <= 1'b1;
    s_wdata <= d;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    while (!(aw_done && w_done)) begin
      @(negedge clk_sys);
      aw_hit = s_awvalid && s_awready;
      w_hit = s_wvalid && s_wready;
      @(posedge clk_sys);
      if (aw_hit) s_awvalid <= 1'b0;
      if (w_hit) s_wvalid <= 1'b0;
      aw_done = aw_done || aw_hit;
      w_done = w_done || w_hit;
    end
    do @(negedge clk_sys); while (s_bvalid !== 1'b1);
    `CHK("bresp", er, s_bresp)
    @(posedge clk_sys);
    s_bready <= 1'b0;
  endtask : axw

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input logic [1:0] er);
    logic hit;
    hit = 1'b0;
    @(posedge clk_sys);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    while (!hit) begin
      @(negedge clk_sys);
      hit = s_arready;
      @(posedge clk_sys);
    end
    s_arvalid <= 1'b0;
    do @(negedge clk_sys); while (s_rvalid !== 1'b1);
    `CHK("rdata", e, s_rdata)
    `CHK("rresp", er, s_rresp)
    @(posedge clk_sys);
    s_rready <= 1'b0;
  endtask : rd_chk

  task automatic fire_d(input logic [31:0] ea, input logic [31:0] pc,
                        input tmde_op_t op, output logic k);
    @(posedge clk_sys);
    d_req <= 1'b1;
    d_addr <= ea;
    d_pc <= pc;
    d_op <= op;
    @(negedge clk_sys);
    k = kill_commit;
    @(posedge clk_sys);
    d_req <= 1'b0;
    @(negedge clk_sys);
  endtask : fire_d

  task automatic t_reset;
    for (int i = 0; i <= 8; i++) rd_chk(8'(i * 4), RST_WORD, RESP_OKAY);
    rd_chk(8'h24, 32'h0, RESP_SLVERR);
    axw(8'h24, 32'h1234_5678, RESP_SLVERR);
    axw(OFF_VECTOR_PREFIX, 32'habcd1234, RESP_OKAY);
    axw(OFF_MACHINE_STATE, MSR_ON, RESP_OKAY);
    rd_chk(OFF_VECTOR_PREFIX, 32'habcd0000, RESP_OKAY);
  endtask : t_reset

  task automatic t_dmiss;
    logic k;
    for (int op = 0; op <= 4; op++) begin
      axw(OFF_SYNDROME, 32'h8000_0101, RESP_OKAY);
      fire_d(32'h0002_0000 + op, 32'h0001_0100 + op, tmde_op_t'(op), k);
      `CHK("kill", 1'b1, k)
      `CHK("redir_v", 1'b1, redirect_valid)
      `CHK("redir_pc", 32'habcd1100, redirect_pc)
      rd_chk(OFF_SAVE_PC, 32'h0001_0100 + op, RESP_OKAY);
      rd_chk(OFF_SAVE_MSR, MSR_ON, RESP_OKAY);
      rd_chk(OFF_FAULT_DATA_ADDR, 32'h0002_0000 + op, RESP_OKAY);
      rd_chk(OFF_SYNDROME, (op != 0) ? 32'h8080_0000 : 32'h8000_0000,
             RESP_OKAY);
    end
    fire_d(32'h0001_0040, 32'h0001_0200, TMDE_OP_STORE, k);
    `CHK("kill_hit", 1'b0, k)
  endtask : t_dmiss

  task automatic t_imiss;
    for (int m = 0; m <= 1; m++) begin
      @(posedge clk_sys);
      i_exec <= 1'b1;
      i_pc <= (m == 0) ? 32'h0003_0200 : 32'h0001_0300;
      @(negedge clk_sys);
      `CHK("ikill", (m == 0), kill_commit)
      @(posedge clk_sys);
      i_exec <= 1'b0;
      @(negedge clk_sys);
      `CHK("iredir_v", (m == 0), redirect_valid)
    end
    `CHK("iredir_pc", 32'habcd1200, redirect_pc)
    rd_chk(OFF_SAVE_PC, 32'h0003_0200, RESP_OKAY);
    rd_chk(OFF_SAVE_MSR, MSR_ON, RESP_OKAY);
  endtask : t_imiss

  task automatic t_debug;
    logic [31:0] e;
    for (int k = 0; k < 8; k++) begin
      axw(OFF_DEBUG_STATUS, 32'h0000_00ff, RESP_OKAY);
      @(posedge clk_sys);
      if (k < 6) dbg_sync_evt <= 6'(1 << k);
      else if (k == 6) dbg_except_evt <= 1'b1;
      else dbg_uncond_evt <= 1'b1;
      @(posedge clk_sys);
      dbg_sync_evt <= 6'h00;
      dbg_except_evt <= 1'b0;
      dbg_uncond_evt <= 1'b0;
      @(negedge clk_sys);
      `CHK("dredir_v", 1'b1, redirect_valid)
      `CHK("dredir_pc", 32'habcd2000, redirect_pc)
      case (k)
        2, 4: e = dbg_cause_pc + 32'h4;
        6: e = dbg_orig_vector;
        7: e = dbg_next_pc;
        default: e = dbg_cause_pc;
      endcase
      rd_chk(OFF_CRIT_SAVE_PC, e,
             RESP_OKAY);
      rd_chk(OFF_CRIT_SAVE_MSR, MSR_ON, RESP_OKAY);
      rd_chk(OFF_DEBUG_STATUS, 32'(1) << k,
             RESP_OKAY);
    end
  endtask : t_debug

  task automatic t_critret;
    logic k;
    axw(OFF_CRIT_SAVE_PC, 32'h0001_0444, RESP_OKAY);
    axw(OFF_CRIT_SAVE_MSR, 32'h0000_0020, RESP_OKAY);
    @(posedge clk_sys);
    crit_ret_exec <= 1'b1;
    @(posedge clk_sys);
    crit_ret_exec <= 1'b0;
    @(negedge clk_sys);
    `CHK("cr_v", 1'b1, redirect_valid)
    `CHK("cr_pc", 32'h0001_0444, redirect_pc)
    `CHK("cr_msr", 32'h0000_0020, msr_out)
    // data translation now off: a lookup failure must not trap
    fire_d(32'h0002_0000, 32'h0001_0500, TMDE_OP_STORE, k);
    `CHK("kill_off", 1'b0, k)
    // debug enable is clear now: an event must not redirect
    @(posedge clk_sys);
    dbg_uncond_evt <= 1'b1;
    @(posedge clk_sys);
    dbg_uncond_evt <= 1'b0;
    @(negedge clk_sys);
    `CHK("dbg_off", 1'b0, redirect_valid)
  endtask : t_critret

  initial begin
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    t_reset();
    t_dmiss();
    t_imiss();
    t_debug();
    t_critret();
    print_verdict();
  end
endmodule : tmde_unit_tb_top
`undef CHK
`default_nettype wire
